// File: logic/dhr_reset_sequencer.v
`timescale 1ns/1ns
`include "dhr_map.vh"

module dhr_reset_sequencer #(
  parameter RELEASE_SLEEP_CYC = `DHR_RELEASE_SLEEP_CYC,
  parameter RELEASE_AWAKE_CYC = `DHR_RELEASE_AWAKE_CYC,
  parameter BLANK_CYC = `DHR_BLANK_CYC
) (
  clk,
  reset_n,
  hw_reset_n,
  sleepOutCmd,
  nvmData,
  nvmAddr,
  nvmRead,
  loadWe,
  loadAddr,
  loadData,
  inReset,
  displayOn,
  sleeping,
  blanking,
  readyForCmd,
  readyForWake
);
  input wire clk;
  input wire reset_n;
  input wire hw_reset_n;
  input wire sleepOutCmd;
  input wire [7:0] nvmData;
  output reg [`DHR_NVM_AW-1:0] nvmAddr;
  output reg nvmRead;
  output reg loadWe;
  output reg [`DHR_NVM_AW-1:0] loadAddr;
  output reg [7:0] loadData;
  output reg inReset;
  output reg displayOn;
  output reg sleeping;
  output reg blanking;
  output reg readyForCmd;
  output reg readyForWake;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_BLANK = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_LOAD = 3'h3;
  localparam [2:0] ST_WAIT = 3'h4;

  wire filtRst;
  reg [2:0] state_reg;
  reg [`DHR_CNT_W-1:0] cnt_reg;
  reg [`DHR_CNT_W-1:0] relLimit_reg;
  reg wasAwake_reg;
  reg rdPend_reg;
  reg [`DHR_NVM_AW-1:0] rdIdx_reg;
  wire restartReq;
  reg [2:0] state_next;
  reg [`DHR_CNT_W-1:0] cnt_next;
  reg [`DHR_CNT_W-1:0] relLimit_next;
  reg wasAwake_next;
  reg rdPend_next;
  reg [`DHR_NVM_AW-1:0] rdIdx_next;
  reg [`DHR_NVM_AW-1:0] nvmAddr_next;
  reg nvmRead_next;
  reg loadWe_next;
  reg [`DHR_NVM_AW-1:0] loadAddr_next;
  reg [7:0] loadData_next;
  reg inReset_next;
  reg displayOn_next;
  reg sleeping_next;
  reg blanking_next;
  reg readyForCmd_next;
  reg readyForWake_next;

  dhr_spike_filter u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .rawIn(hw_reset_n),
    .filtOut(filtRst)
  );

  // Restart is held off in blank and hold so a started blanking sequence always completes
  assign restartReq = !filtRst && state_reg != ST_BLANK && state_reg != ST_HOLD;

  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    relLimit_next = relLimit_reg;
    wasAwake_next = wasAwake_reg;
    rdPend_next = rdPend_reg;
    rdIdx_next = rdIdx_reg;
    nvmAddr_next = nvmAddr;
    nvmRead_next = 1'b0;
    loadWe_next = 1'b0;
    loadAddr_next = loadAddr;
    loadData_next = loadData;
    inReset_next = inReset;
    displayOn_next = displayOn;
    sleeping_next = sleeping;
    blanking_next = blanking;
    readyForCmd_next = readyForCmd;
    readyForWake_next = readyForWake;
    if (restartReq) begin
      wasAwake_next = !sleeping;
      inReset_next = 1'b1;
      readyForCmd_next = 1'b0;
      readyForWake_next = 1'b0;
      displayOn_next = 1'b0;
      cnt_next = 22'h000000;
      blanking_next = !sleeping;
      state_next = sleeping ? ST_HOLD : ST_BLANK;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (sleepOutCmd && readyForWake && sleeping) begin
            sleeping_next = 1'b0;
            displayOn_next = 1'b1;
          end
        end
        ST_BLANK: begin
          if (cnt_reg < BLANK_CYC - 1) begin
            cnt_next = cnt_reg + 22'h000001;
          end else begin
            blanking_next = 1'b0;
            sleeping_next = 1'b1;
            state_next = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (filtRst) begin
            cnt_next = 22'h000000;
            rdIdx_next = 3'h0;
            rdPend_next = 1'b0;
            blanking_next = 1'b0;
            sleeping_next = 1'b1;
            relLimit_next = wasAwake_reg ? RELEASE_AWAKE_CYC[21:0] : RELEASE_SLEEP_CYC[21:0];
            state_next = ST_LOAD;
          end
        end
        ST_LOAD: begin
          cnt_next = cnt_reg + 22'h000001;
          if (!rdPend_reg) begin
            nvmAddr_next = rdIdx_reg;
            nvmRead_next = 1'b1;
            rdPend_next = 1'b1;
          end else begin
            loadWe_next = 1'b1;
            loadAddr_next = rdIdx_reg;
            loadData_next = nvmData;
            rdPend_next = 1'b0;
            rdIdx_next = rdIdx_reg + 3'h1;
            if (rdIdx_reg == `DHR_NVM_WORDS - 1) begin
              inReset_next = 1'b0;
              state_next = ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (cnt_reg < relLimit_reg - 1) begin
            cnt_next = cnt_reg + 22'h000001;
          end else begin
            readyForCmd_next = 1'b1;
            readyForWake_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Power-on counts as a reset release, so the settings are reloaded before first use
      state_reg <= ST_HOLD;
      cnt_reg <= 22'h000000;
      relLimit_reg <= 22'h000000;
      wasAwake_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      rdIdx_reg <= 3'h0;
      nvmAddr <= 3'h0;
      nvmRead <= 1'b0;
      loadWe <= 1'b0;
      loadAddr <= 3'h0;
      loadData <= 8'h00;
      inReset <= 1'b1;
      displayOn <= 1'b0;
      sleeping <= 1'b1;
      blanking <= 1'b0;
      readyForCmd <= 1'b0;
      readyForWake <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      relLimit_reg <= relLimit_next;
      wasAwake_reg <= wasAwake_next;
      rdPend_reg <= rdPend_next;
      rdIdx_reg <= rdIdx_next;
      nvmAddr <= nvmAddr_next;
      nvmRead <= nvmRead_next;
      loadWe <= loadWe_next;
      loadAddr <= loadAddr_next;
      loadData <= loadData_next;
      inReset <= inReset_next;
      displayOn <= displayOn_next;
      sleeping <= sleeping_next;
      blanking <= blanking_next;
      readyForCmd <= readyForCmd_next;
      readyForWake <= readyForWake_next;
    end
  end
endmodule // dhr_reset_sequencer

// File: logic/dhr_map.vh
`ifndef DHR_MAP_VH
`define DHR_MAP_VH

// Clock rate in kHz (25 MHz)
`define DHR_CLK_KHZ 25000
// Spike filter limits in microseconds
`define DHR_SPIKE_REJECT_US 5
`define DHR_SPIKE_ACCEPT_US 9
// Reject rounds down, accept rounds up
`define DHR_REJECT_CYC ((`DHR_SPIKE_REJECT_US * `DHR_CLK_KHZ) / 1000)
`define DHR_ACCEPT_CYC ((`DHR_SPIKE_ACCEPT_US * `DHR_CLK_KHZ + 999) / 1000)
// Release intervals in milliseconds
`define DHR_RELEASE_SLEEP_MS 5
`define DHR_RELEASE_AWAKE_MS 120
`define DHR_RELEASE_SLEEP_CYC (`DHR_RELEASE_SLEEP_MS * `DHR_CLK_KHZ)
`define DHR_RELEASE_AWAKE_CYC (`DHR_RELEASE_AWAKE_MS * `DHR_CLK_KHZ)
// Blanking sequence length and NVM words reloaded
`define DHR_BLANK_MS 100
`define DHR_BLANK_CYC (`DHR_BLANK_MS * `DHR_CLK_KHZ)
`define DHR_NVM_WORDS 8
`define DHR_NVM_AW 3
`define DHR_CNT_W 22
`define DHR_FLT_W 8

`endif

// File: logic/dhr_spike_filter.v
`timescale 1ns/1ns
`include "dhr_map.vh"

// Accepts a level change only when it persists for the full accept window.
// Anything shorter than the reject window never shows at the output.
module dhr_spike_filter (
  clk,
  reset_n,
  rawIn,
  filtOut
);
  input wire clk;
  input wire reset_n;
  input wire rawIn;
  output reg filtOut;

  reg [`DHR_FLT_W-1:0] cnt_reg;

  // same filter on glitches inside reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 8'h00;
      filtOut <= 1'b1;
    end else if (rawIn == filtOut) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == `DHR_ACCEPT_CYC - 1) begin
      cnt_reg <= 8'h00;
      filtOut <= rawIn;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule // dhr_spike_filter

// File: sim/dhr_reset_checker.sv
`timescale 1ns/1ns
module dhr_reset_checker (
  input wire clk,
  input wire reset_n,
  input wire hw_reset_n,
  input wire nvmRead,
  input wire [2:0] nvmAddr,
  input wire loadWe,
  input wire [2:0] loadAddr,
  input wire inReset,
  input wire displayOn,
  input wire sleeping,
  input wire blanking,
  input wire readyForCmd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_spike_ignored: assert property (!inReset && $fell(hw_reset_n) |=> !inReset [*8])
    else $error("reset taken too early");
  a_glitch_held: assert property (inReset && $rose(hw_reset_n) |=> inReset [*8])
    else $error("reset dropped on a glitch");
  a_reload_pair: assert property (nvmRead |=> loadWe && loadAddr == $past(nvmAddr))
    else $error("reload write missing");
  a_blank_bound: assert property ($rose(blanking) |-> ##[1:150] !blanking)
    else $error("blanking too long");
  a_reset_dark: assert property (inReset |-> !displayOn)
    else $error("display lit in reset");
  a_ready_bound: assert property ($fell(inReset) |-> ##[1:250] readyForCmd)
    else $error("ready too late");
  a_exit_asleep: assert property ($fell(inReset) |-> sleeping && !displayOn)
    else $error("left reset awake");
endmodule // dhr_reset_checker

bind dhr_reset_sequencer dhr_reset_checker dhr_reset_checker_inst (.clk, .reset_n, .hw_reset_n,
  .nvmRead, .nvmAddr, .loadWe, .loadAddr, .inReset, .displayOn, .sleeping, .blanking, .readyForCmd);

// File: sim/dhr_host_model.sv
`timescale 1ns/1ns
module dhr_host_model (
  input wire clk,
  output reg hw_reset_n,
  output reg sleepOutCmd
);
  integer sinceRel = 0;
  initial begin
    hw_reset_n = 1'b1;
    sleepOutCmd = 1'b0;
  end
  always @(negedge clk) sinceRel <= hw_reset_n ? sinceRel + 1 : 0;
  task drive(input lvl, input integer n);
    @(negedge clk);
    hw_reset_n = lvl;
    repeat (n) @(negedge clk);
  endtask
  task wake;
    wait (sinceRel > 700);
    @(negedge clk);
    sleepOutCmd = 1'b1;
    @(negedge clk);
    sleepOutCmd = 1'b0;
  endtask
endmodule // dhr_host_model

// File: sim/test_dhr_reset_sequencer.sv
`timescale 1ns/1ns
module test_dhr_reset_sequencer;
  reg clk = 0;
  reg reset_n = 0;
  reg [7:0] nvmData = 8'h00;
  wire hw_reset_n, sleepOutCmd, nvmRead, loadWe, inReset, displayOn, sleeping, blanking, readyForCmd, readyForWake;
  wire [2:0] nvmAddr, loadAddr;
  wire [7:0] loadData;
  integer miscompares = 0, comparisons = 0, loads = 0;
  always #20 clk = ~clk;
  dhr_host_model dhr_host_model_inst (.clk(clk), .hw_reset_n(hw_reset_n), .sleepOutCmd(sleepOutCmd));
  dhr_reset_sequencer #(.RELEASE_SLEEP_CYC(50), .RELEASE_AWAKE_CYC(200), .BLANK_CYC(100)) dhr_reset_sequencer_inst (
    .clk, .reset_n, .hw_reset_n, .sleepOutCmd, .nvmData, .nvmAddr, .nvmRead, .loadWe, .loadAddr,
    .loadData, .inReset, .displayOn, .sleeping, .blanking, .readyForCmd, .readyForWake);
  task check(input ok, input [8*12-1:0] msg);
    comparisons++;
    if (!ok) begin
      miscompares++;
      $display("MISMATCH t=%0t %0s", $time, msg);
    end
  endtask
  // Simple NVM: word n holds a0+n
  always @(negedge clk) begin
    if (nvmRead) nvmData <= 8'ha0 + nvmAddr;
    if (loadWe) loads++;
    if (loadWe) check(loadData === 8'ha0 + loadAddr, "reload data");
  end
  // Limits: filter window (225, none at power-on) plus release interval plus a small margin
  task waitReady(input integer limit);
    integer n;
    n = 0;
    while (readyForCmd !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(readyForCmd === 1'b1 && n <= limit, "ready late");
  endtask
  task t_spike;
    loads = 0;
    dhr_host_model_inst.drive(0, 120);
    dhr_host_model_inst.drive(1, 300);
    check(inReset === 1'b0 && loads == 0, "spike");
    $display("spike done");
  endtask
  task t_sleep;
    loads = 0;
    dhr_host_model_inst.drive(0, 300);
    check(inReset === 1'b1 && displayOn === 1'b0 && blanking === 1'b0, "asleep rst");
    dhr_host_model_inst.drive(1, 0);
    waitReady(283);
    check(loads == 8 && sleeping === 1'b1 && displayOn === 1'b0, "exit");
    $display("sleep reset done");
  endtask
  task t_wake;
    dhr_host_model_inst.wake;
    repeat (3) @(negedge clk);
    check(sleeping === 1'b0 && displayOn === 1'b1, "wake");
    $display("wake done");
  endtask
  task t_awake;
    loads = 0;
    dhr_host_model_inst.drive(0, 240);
    check(blanking === 1'b1, "blank");
    // Stay low past the blanking end so the glitch lands in the hold phase
    dhr_host_model_inst.drive(0, 100);
    dhr_host_model_inst.drive(1, 100);
    check(inReset === 1'b1 && loads == 0, "glitch");
    dhr_host_model_inst.drive(0, 100);
    dhr_host_model_inst.drive(1, 0);
    waitReady(433);
    check(loads == 8 && sleeping === 1'b1 && displayOn === 1'b0, "awake rst");
    $display("awake reset done");
  endtask
  task print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    waitReady(58);
    check(loads == 8 && inReset === 1'b0, "power on");
    t_spike;
    t_sleep;
    t_wake;
    t_awake;
    print_verdict;
  end
  // Whole run is a few thousand cycles
  initial begin
    #2000000;
    miscompares++;
    print_verdict;
  end
endmodule // test_dhr_reset_sequencer
